/* File: hdl/sod_map.svh */
// Notes on behaviour
// RULE1 - host holds chip select low across every byte of one command.
// RULE2 - system opcodes and single read decode on seventh falling serial clock edge; single read decodes on the eighth here.
// RULE3 - register read and write headers decode on eighth falling edge.
// RULE4 - 02h exits standby, 04h enters standby, 06h resets.
// RULE5 - 08h starts or resynchronises conversions, 0Ah stops them; start while running is ignored here.
// RULE6 - 10h/11h/12h continuous read on/off, single read; continuous read after power-up.
// RULE7 - read header 001rrrrr, write header 010rrrrr, then count byte 000nnnnn.
// RULE8 - count field means registers to transfer minus one.
// RULE9 - 60h reads FIFO, second byte gives item count minus one.
// RULE10 - register read ignored while continuous read active.
// RULE11 - headers reach only addresses up to 1Fh.
// RULE12 - with CRC enabled each command carries its fixed CRC byte.
// RULE13 - host waits 4 master clocks after exit standby.
// RULE14 - enter standby shuts down everything but the reference.
// RULE15 - in standby host sends only exit standby.
// RULE16 - reset restarts filter and restores register defaults.
// RULE17 - host sends nothing during the 9 modulator cycles of reset.
// RULE18 - start has no effect while running; host spaces start and stop.
// RULE19 - stop lets current conversion finish; no effect when halted.
// RULE20 - host holds start pin low while commanding conversions.
// RULE21 - when locked only register read, single read and unlock are accepted.
// RULE22 - lock cleared by internal reset or chip select rising.
// RULE23 - host sets trim enable before offset trim, repeats after gain change.
// RULE24 - host stops continuous read before other commands except lock/unlock.
// RULE25 - host leaves 4 master clocks between bytes.
// RULE26 - unknown first bytes are ignored with state unchanged.
`ifndef SOD_MAP_SVH
`define SOD_MAP_SVH
`define SOD_OP_WAKE 8'h02
`define SOD_OP_STANDBY 8'h04
`define SOD_OP_RESET 8'h06
`define SOD_OP_START 8'h08
`define SOD_OP_STOP 8'h0a
`define SOD_OP_CONTINUOUS_READ_CMD 8'h10
`define SOD_OP_HALT_CONTINUOUS_READ_CMD 8'h11
`define SOD_OP_RDATA 8'h12
`define SOD_OP_LOCK 8'h15
`define SOD_OP_UNLOCK 8'h16
`define SOD_OP_TRIM 8'h1a
`define SOD_OP_FIFO 8'h60
`define SOD_HDR_REGISTER_READ_CMD 3'b001
`define SOD_HDR_REGISTER_WRITE_CMD 3'b010
`define SOD_HDR_CNT 3'b000
`define SOD_CRC_WAKE 8'h0e
`define SOD_CRC_STANDBY 8'h1c
`define SOD_CRC_RESET_A 8'h12
`define SOD_CRC_RESET_B 8'h13
`define SOD_CRC_START 8'h38
`define SOD_CRC_STOP 8'h36
`define SOD_CRC_LOCK 8'h6b
`define SOD_CRC_UNLOCK 8'h62
`define SOD_CRC_TRIM 8'h46
`define SOD_CRC_CONTINUOUS_READ_CMD 8'h70
`define SOD_CRC_HALT_CONTINUOUS_READ_CMD 8'h77
`define SOD_CRC_RDATA 8'h7e
`define SOD_SYS_EDGE 3'd6
`define SOD_HDR_EDGE 3'd7
`endif

/* File: hdl/sod_pkg.sv */
package sod_pkg;
	typedef enum logic [3:0] {
		SOD_CMD_NONE = 4'h0,
		SOD_CMD_WAKE = 4'h1,
		SOD_CMD_STANDBY = 4'h2,
		SOD_CMD_RESET = 4'h3,
		SOD_CMD_START = 4'h4,
		SOD_CMD_STOP = 4'h5,
		SOD_CMD_CONTINUOUS_READ_CMD = 4'h6,
		SOD_CMD_HALT_CONTINUOUS_READ_CMD = 4'h7,
		SOD_CMD_RDATA = 4'h8,
		SOD_CMD_LOCK = 4'h9,
		SOD_CMD_UNLOCK = 4'ha,
		SOD_CMD_TRIM = 4'hb,
		SOD_CMD_REGISTER_READ_CMD = 4'hc,
		SOD_CMD_REGISTER_WRITE_CMD = 4'hd,
		SOD_CMD_FIFO = 4'he
	} sod_cmd_t;
	typedef struct packed {
		sod_cmd_t cmd;
		logic [4:0] addr;
		logic [4:0] count;
	} sod_req_t;
	typedef enum logic [1:0] {
		SOD_ST_OPCODE = 2'b00,
		SOD_ST_CRC = 2'b01,
		SOD_ST_COUNT = 2'b10,
		SOD_ST_DATA = 2'b11
	} sod_state_t;
endpackage : sod_pkg

/* File: hdl/sod_sync.sv */
`timescale 1ns/100ps
module sod_sync (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic d_in,
	output logic q_out
);
	logic s1_reg;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_reg <= 1'b0;
			q_out <= 1'b0;
		end else begin
			s1_reg <= d_in;
			q_out <= s1_reg;
		end
	end
endmodule : sod_sync

/* File: hdl/sod_handoff.sv */
`timescale 1ns/100ps
// toggle handshake carrying one request word into the master clock domain;
// the word is held stable in the source until the toggle has crossed
module sod_handoff (
	input wire logic src_clk_in,
	input wire logic src_arst_n_in,
	input wire logic src_valid_in,
	input wire sod_pkg::sod_req_t src_req_in,
	input wire logic dst_clk_in,
	input wire logic dst_arst_n_in,
	output logic dst_valid_out,
	output sod_pkg::sod_req_t dst_req_out
);
	logic tog_reg;
	sod_pkg::sod_req_t hold_reg;
	logic tog_sync;
	logic tog_seen_reg;
	always_ff @(posedge src_clk_in or negedge src_arst_n_in) begin
		if (!src_arst_n_in) begin
			tog_reg <= 1'b0;
			hold_reg <= '0;
		end else if (src_valid_in) begin
			tog_reg <= ~tog_reg;
			hold_reg <= src_req_in;
		end
	end
	sod_sync u_sync (
		.clk_in(dst_clk_in),
		.arst_n_in(dst_arst_n_in),
		.d_in(tog_reg),
		.q_out(tog_sync)
	);
	always_ff @(posedge dst_clk_in or negedge dst_arst_n_in) begin
		if (!dst_arst_n_in) begin
			tog_seen_reg <= 1'b0;
			dst_valid_out <= 1'b0;
			dst_req_out <= '0;
		end else begin
			tog_seen_reg <= tog_sync;
			dst_valid_out <= tog_sync ^ tog_seen_reg;
			if (tog_sync ^ tog_seen_reg) begin
				dst_req_out <= hold_reg;
			end
		end
	end
endmodule : sod_handoff

/* File: hdl/sod_decoder.sv */
`timescale 1ns/100ps
`include "sod_map.svh"
// serial side runs on the falling edge of the serial clock (inverted clock port);
// the command state lives on ref_clk_in behind two toggle crossings (request word and chip select rise)
module sod_decoder (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	input wire logic crc_en_in,
	input wire logic trim_enable_bit_in,
	output logic standby_out,
	output logic converting_out,
	output logic continuous_read_out,
	output logic locked_out,
	output logic filter_restart_out,
	output logic reg_defaults_out,
	output logic single_read_out,
	output logic offset_trim_out,
	output logic xfer_valid_out,
	output sod_pkg::sod_req_t xfer_req_out
);
	// serial domain
	logic sclk_n;
	logic [6:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	sod_pkg::sod_state_t state_reg;
	sod_pkg::sod_req_t pend_reg;
	logic [7:0] crc_exp_reg;
	logic [7:0] crc_alt_reg;
	logic [7:0] byte_now;
	logic [6:0] head_now;
	logic emit_valid;
	sod_pkg::sod_req_t emit_req;
	logic crc_en_s;
	logic cs_rise_tog_reg;
	sod_pkg::sod_state_t state_next;
	sod_pkg::sod_req_t pend_next;
	logic [7:0] crc_exp_next;
	logic [7:0] crc_alt_next;
	sod_pkg::sod_cmd_t op_cmd;
	assign sclk_n = ~sclk_in;
	assign byte_now = {shift_reg, din_in};
	// the seventh bit is still on the pin at the seventh edge
	assign head_now = byte_now[6:0];
	// system opcode lookup on the first seven bits; lsb still to come
	function automatic sod_pkg::sod_cmd_t sys_decode(input logic [6:0] h);
		sod_pkg::sod_cmd_t c;
		c = sod_pkg::SOD_CMD_NONE;
		case (h)
			`SOD_OP_WAKE >> 1: c = sod_pkg::SOD_CMD_WAKE;
			`SOD_OP_STANDBY >> 1: c = sod_pkg::SOD_CMD_STANDBY;
			`SOD_OP_RESET >> 1: c = sod_pkg::SOD_CMD_RESET;
			`SOD_OP_START >> 1: c = sod_pkg::SOD_CMD_START;
			`SOD_OP_STOP >> 1: c = sod_pkg::SOD_CMD_STOP;
			`SOD_OP_TRIM >> 1: c = sod_pkg::SOD_CMD_TRIM;
			default: c = sod_pkg::SOD_CMD_NONE;
		endcase
		return c;
	endfunction : sys_decode
	// opcodes that differ only in the last bit need the full byte
	function automatic sod_pkg::sod_cmd_t byte_decode(input logic [7:0] b);
		sod_pkg::sod_cmd_t c;
		c = sod_pkg::SOD_CMD_NONE;
		case (b)
			`SOD_OP_CONTINUOUS_READ_CMD: c = sod_pkg::SOD_CMD_CONTINUOUS_READ_CMD;
			`SOD_OP_HALT_CONTINUOUS_READ_CMD: c = sod_pkg::SOD_CMD_HALT_CONTINUOUS_READ_CMD;
			`SOD_OP_LOCK: c = sod_pkg::SOD_CMD_LOCK;
			`SOD_OP_UNLOCK: c = sod_pkg::SOD_CMD_UNLOCK;
			`SOD_OP_FIFO: c = sod_pkg::SOD_CMD_FIFO;
			default: c = sod_pkg::SOD_CMD_NONE;
		endcase
		if (b[7:5] == `SOD_HDR_REGISTER_READ_CMD) begin
			c = sod_pkg::SOD_CMD_REGISTER_READ_CMD; // RULE7
		end else if (b[7:5] == `SOD_HDR_REGISTER_WRITE_CMD) begin
			c = sod_pkg::SOD_CMD_REGISTER_WRITE_CMD; // RULE7
		end
		return c;
	endfunction : byte_decode
	function automatic logic [7:0] crc_of(input sod_pkg::sod_cmd_t c);
		logic [7:0] v;
		v = 8'h00;
		case (c)
			sod_pkg::SOD_CMD_WAKE: v = `SOD_CRC_WAKE;
			sod_pkg::SOD_CMD_STANDBY: v = `SOD_CRC_STANDBY;
			sod_pkg::SOD_CMD_RESET: v = `SOD_CRC_RESET_A;
			sod_pkg::SOD_CMD_START: v = `SOD_CRC_START;
			sod_pkg::SOD_CMD_STOP: v = `SOD_CRC_STOP;
			sod_pkg::SOD_CMD_LOCK: v = `SOD_CRC_LOCK;
			sod_pkg::SOD_CMD_UNLOCK: v = `SOD_CRC_UNLOCK;
			sod_pkg::SOD_CMD_TRIM: v = `SOD_CRC_TRIM;
			sod_pkg::SOD_CMD_CONTINUOUS_READ_CMD: v = `SOD_CRC_CONTINUOUS_READ_CMD;
			sod_pkg::SOD_CMD_HALT_CONTINUOUS_READ_CMD: v = `SOD_CRC_HALT_CONTINUOUS_READ_CMD;
			sod_pkg::SOD_CMD_RDATA: v = `SOD_CRC_RDATA;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : crc_of
	sod_sync u_crc_sync (
		.clk_in(sclk_n),
		.arst_n_in(arst_n_in),
		.d_in(crc_en_in),
		.q_out(crc_en_s)
	);
	// chip select high is the serial interface reset: framing restarts
	always_ff @(posedge sclk_n or posedge cs_n_in) begin
		if (cs_n_in) begin
			shift_reg <= 7'h00;
			bit_cnt_reg <= 3'd0;
		end else begin
			shift_reg <= byte_now[6:0];
			bit_cnt_reg <= bit_cnt_reg + 3'd1;
		end
	end
	// command sequencing state; framing restarts when chip select goes high
	always_ff @(posedge sclk_n or posedge cs_n_in) begin
		if (cs_n_in) begin
			state_reg <= sod_pkg::SOD_ST_OPCODE;
			pend_reg <= '0;
			crc_exp_reg <= 8'h00;
			crc_alt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			crc_exp_reg <= crc_exp_next;
			crc_alt_reg <= crc_alt_next;
		end
	end
	// emit is combinational so the handoff takes it on the completing edge;
	// a registered emit would be lost when the frame ends on that edge
	always_comb begin
		op_cmd = (byte_decode(byte_now) != sod_pkg::SOD_CMD_NONE) ? byte_decode(byte_now) :
			((byte_now == `SOD_OP_RDATA) ? sod_pkg::SOD_CMD_RDATA :
			sys_decode(byte_now[7:1]));
		state_next = state_reg;
		pend_next = pend_reg;
		crc_exp_next = crc_exp_reg;
		crc_alt_next = crc_alt_reg;
		emit_valid = 1'b0;
		emit_req = '0;
		case (state_reg)
			sod_pkg::SOD_ST_OPCODE: begin
				if (bit_cnt_reg == `SOD_SYS_EDGE &&
					sys_decode(head_now) != sod_pkg::SOD_CMD_NONE &&
					!crc_en_s) begin
					emit_valid = 1'b1; // RULE2 RULE4 RULE5
					emit_req = '{cmd: sys_decode(head_now), addr: 5'h00, count: 5'h00};
				end
				if (bit_cnt_reg == `SOD_HDR_EDGE) begin
					pend_next = '{cmd: byte_decode(byte_now), addr: byte_now[4:0], count: 5'h00};
					if (byte_decode(byte_now) == sod_pkg::SOD_CMD_REGISTER_READ_CMD ||
						byte_decode(byte_now) == sod_pkg::SOD_CMD_REGISTER_WRITE_CMD ||
						byte_decode(byte_now) == sod_pkg::SOD_CMD_FIFO) begin
						state_next = sod_pkg::SOD_ST_COUNT; // RULE3 RULE9 RULE11
					end else if (crc_en_s && op_cmd != sod_pkg::SOD_CMD_NONE) begin
						state_next = sod_pkg::SOD_ST_CRC; // RULE12
						pend_next.cmd = op_cmd;
						crc_exp_next = crc_of(op_cmd);
						crc_alt_next = (byte_now == `SOD_OP_RESET) ? `SOD_CRC_RESET_B : 8'h00;
					end else if (!crc_en_s && (byte_now == `SOD_OP_RDATA ||
						byte_decode(byte_now) != sod_pkg::SOD_CMD_NONE)) begin
						// continuous read on and continuous-read exit share the top seven bits
						emit_valid = 1'b1; // RULE6
						emit_req = '{cmd: op_cmd, addr: 5'h00, count: 5'h00};
					end
					// anything else falls through with nothing emitted RULE26
				end
			end
			sod_pkg::SOD_ST_CRC: begin
				if (bit_cnt_reg == `SOD_HDR_EDGE) begin
					state_next = sod_pkg::SOD_ST_OPCODE;
					if (byte_now == crc_exp_reg ||
						(crc_alt_reg != 8'h00 && byte_now == crc_alt_reg)) begin
						emit_valid = 1'b1; // RULE12
						emit_req = pend_reg;
					end
				end
			end
			sod_pkg::SOD_ST_COUNT: begin
				if (bit_cnt_reg == `SOD_HDR_EDGE) begin
					if (byte_now[7:5] == `SOD_HDR_CNT) begin
						emit_valid = 1'b1; // RULE8
						emit_req = '{cmd: pend_reg.cmd, addr: pend_reg.addr,
							count: byte_now[4:0]};
						state_next = sod_pkg::SOD_ST_DATA;
					end else begin
						state_next = sod_pkg::SOD_ST_OPCODE;
					end
				end
			end
			sod_pkg::SOD_ST_DATA: begin
				// data bytes belong to the transfer engine until chip select rises
				state_next = sod_pkg::SOD_ST_DATA;
			end
			default: state_next = sod_pkg::SOD_ST_OPCODE;
		endcase
	end
	// chip select rising is an event for the lock; toggled in the serial domain
	always_ff @(posedge cs_n_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cs_rise_tog_reg <= 1'b0;
		end else begin
			cs_rise_tog_reg <= ~cs_rise_tog_reg;
		end
	end
	// master clock domain
	logic req_valid;
	sod_pkg::sod_req_t req;
	logic cs_tog_sync;
	logic cs_tog_seen_reg;
	logic cs_rise;
	sod_pkg::sod_cmd_t cmd;
	logic allow;
	sod_handoff u_handoff (
		.src_clk_in(sclk_n),
		.src_arst_n_in(arst_n_in),
		.src_valid_in(emit_valid),
		.src_req_in(emit_req),
		.dst_clk_in(ref_clk_in),
		.dst_arst_n_in(arst_n_in),
		.dst_valid_out(req_valid),
		.dst_req_out(req)
	);
	sod_sync u_cs_sync (
		.clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.d_in(cs_rise_tog_reg),
		.q_out(cs_tog_sync)
	);
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cs_tog_seen_reg <= 1'b0;
		end else begin
			cs_tog_seen_reg <= cs_tog_sync;
		end
	end
	assign cs_rise = cs_tog_sync ^ cs_tog_seen_reg;
	assign cmd = req_valid ? req.cmd : sod_pkg::SOD_CMD_NONE;
	// acceptance filter for lock and continuous read
	always_comb begin
		allow = 1'b1;
		if (locked_out) begin
			allow = (cmd == sod_pkg::SOD_CMD_REGISTER_READ_CMD) || (cmd == sod_pkg::SOD_CMD_RDATA) ||
				(cmd == sod_pkg::SOD_CMD_UNLOCK); // RULE21
		end
		if (continuous_read_out && cmd == sod_pkg::SOD_CMD_REGISTER_READ_CMD) begin
			allow = 1'b0; // RULE10
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			standby_out <= 1'b0;
		end else if (allow && cmd == sod_pkg::SOD_CMD_STANDBY) begin
			standby_out <= 1'b1; // RULE14
		end else if (allow && (cmd == sod_pkg::SOD_CMD_WAKE || cmd == sod_pkg::SOD_CMD_RESET)) begin
			standby_out <= 1'b0; // RULE4
		end
	end
	// stop only drops the run level; the engine finishes the conversion in flight
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			converting_out <= 1'b0;
		end else if (allow && cmd == sod_pkg::SOD_CMD_START) begin
			converting_out <= 1'b1; // RULE5 RULE18
		end else if (allow && (cmd == sod_pkg::SOD_CMD_STOP || cmd == sod_pkg::SOD_CMD_RESET)) begin
			converting_out <= 1'b0; // RULE19
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			continuous_read_out <= 1'b1; // RULE6
		end else if (allow && (cmd == sod_pkg::SOD_CMD_CONTINUOUS_READ_CMD || cmd == sod_pkg::SOD_CMD_RESET)) begin
			continuous_read_out <= 1'b1;
		end else if (allow && cmd == sod_pkg::SOD_CMD_HALT_CONTINUOUS_READ_CMD) begin
			continuous_read_out <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			locked_out <= 1'b0;
		end else if (cs_rise || (allow && cmd == sod_pkg::SOD_CMD_RESET)) begin
			locked_out <= 1'b0; // RULE22
		end else if (allow && cmd == sod_pkg::SOD_CMD_LOCK) begin
			locked_out <= 1'b1; // RULE21
		end else if (allow && cmd == sod_pkg::SOD_CMD_UNLOCK) begin
			locked_out <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			filter_restart_out <= 1'b0;
			reg_defaults_out <= 1'b0;
			single_read_out <= 1'b0;
			offset_trim_out <= 1'b0;
		end else begin
			filter_restart_out <= allow && (cmd == sod_pkg::SOD_CMD_RESET ||
				(cmd == sod_pkg::SOD_CMD_START && !converting_out)); // RULE16 RULE18
			reg_defaults_out <= allow && cmd == sod_pkg::SOD_CMD_RESET; // RULE16
			single_read_out <= allow && cmd == sod_pkg::SOD_CMD_RDATA;
			// trim only runs when the enable bit was set beforehand
			offset_trim_out <= allow && cmd == sod_pkg::SOD_CMD_TRIM && trim_enable_bit_in;
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			xfer_valid_out <= 1'b0;
			xfer_req_out <= '0;
		end else begin
			xfer_valid_out <= allow && (cmd == sod_pkg::SOD_CMD_REGISTER_READ_CMD ||
				cmd == sod_pkg::SOD_CMD_REGISTER_WRITE_CMD || cmd == sod_pkg::SOD_CMD_FIFO);
			if (req_valid) begin
				xfer_req_out <= req;
			end
		end
	end
endmodule : sod_decoder

/* File: bench/sod_decoder_asserts.sv */
`timescale 1ns/100ps
module sod_decoder_chk (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	input wire logic crc_en_in,
	input wire logic trim_enable_bit_in,
	input wire logic standby_out,
	input wire logic converting_out,
	input wire logic continuous_read_out,
	input wire logic locked_out,
	input wire logic filter_restart_out,
	input wire logic reg_defaults_out,
	input wire logic single_read_out,
	input wire logic offset_trim_out,
	input wire logic xfer_valid_out,
	input wire sod_pkg::sod_req_t xfer_req_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_reset_restart: assert property (reg_defaults_out |-> filter_restart_out)
		else $error("defaults pulse without filter restart");
	a_reset_state: assert property (reg_defaults_out |=>
		continuous_read_out && !converting_out && !locked_out && !standby_out)
		else $error("state not at defaults after reset command");
	// two cycles back; a restart pulse from start rises in the same cycle as the run level
	a_start_running: assert property (converting_out && $past(converting_out, 2) |->
		!filter_restart_out || reg_defaults_out)
		else $error("start restarted a running conversion");
	a_lock_holds: assert property (locked_out && $past(locked_out) |->
		$stable(converting_out) && $stable(standby_out) && !offset_trim_out && !reg_defaults_out)
		else $error("locked interface changed state");
	a_lock_cs_clear: assert property ($rose(cs_n_in) |-> ##[1:8] !locked_out)
		else $error("lock survived chip select rise");
	a_register_read_cmd_cont: assert property (xfer_valid_out &&
		xfer_req_out.cmd == sod_pkg::SOD_CMD_REGISTER_READ_CMD |-> !continuous_read_out)
		else $error("register read accepted in continuous read");
	a_xfer_kind: assert property (xfer_valid_out |-> xfer_req_out.cmd inside
		{sod_pkg::SOD_CMD_REGISTER_READ_CMD, sod_pkg::SOD_CMD_REGISTER_WRITE_CMD, sod_pkg::SOD_CMD_FIFO})
		else $error("transfer header with wrong kind");
	a_trim_gate: assert property (offset_trim_out |-> trim_enable_bit_in)
		else $error("offset trim without enable");
	c_xfer: cover property (xfer_valid_out);
	c_trim: cover property (offset_trim_out);
	c_unlock: cover property (locked_out ##1 !locked_out);
endmodule : sod_decoder_chk

bind sod_decoder sod_decoder_chk u_chk (.ref_clk_in, .arst_n_in, .sclk_in, .cs_n_in, .din_in,
	.crc_en_in, .trim_enable_bit_in, .standby_out, .converting_out, .continuous_read_out,
	.locked_out, .filter_restart_out, .reg_defaults_out, .single_read_out, .offset_trim_out,
	.xfer_valid_out, .xfer_req_out);

/* File: bench/sod_host.sv */
`timescale 1ns/100ps
module sod_host (
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out
);
	// serial clock idles low and runs only inside a frame
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end
	task automatic open_frame();
		#3;
		cs_n_out = 1'b0;
		#40;
	endtask : open_frame
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			din_out = b[i];
			sclk_out = 1'b1;
			#40;
			sclk_out = 1'b0;
			#40;
		end
		#100;
	endtask : send_byte
	task automatic close_frame();
		cs_n_out = 1'b1;
		// released line must not keep showing the last bit
		din_out = ~din_out;
	endtask : close_frame
endmodule : sod_host

/* File: bench/sod_decoder_tb_top.sv */
`timescale 1ns/100ps
module sod_decoder_tb_top;
	logic ref_clk_in = 1'b0;
	logic arst_n_in;
	logic crc_en_in;
	logic trim_enable_bit_in;
	logic sclk_in, cs_n_in, din_in, standby_out, converting_out, continuous_read_out, locked_out;
	logic filter_restart_out, reg_defaults_out, single_read_out, offset_trim_out, xfer_valid_out;
	sod_pkg::sod_req_t xfer_req_out, last_req;
	int fail_count = 0;
	int check_count = 0;
	logic [3:0] n_restart = 4'h0, n_defaults = 4'h0, n_single = 4'h0, n_trim = 4'h0;
	logic [1:0] n_xfer = 2'd0;
	always #5 ref_clk_in = ~ref_clk_in;
	// pulses last one cycle, so they are tallied where they stand
	always @(posedge ref_clk_in) begin
		if (filter_restart_out === 1'b1) n_restart <= n_restart + 4'h1;
		if (reg_defaults_out === 1'b1) n_defaults <= n_defaults + 4'h1;
		if (single_read_out === 1'b1) n_single <= n_single + 4'h1;
		if (offset_trim_out === 1'b1) n_trim <= n_trim + 4'h1;
		if (xfer_valid_out === 1'b1) begin
			n_xfer <= n_xfer + 2'd1;
			last_req <= xfer_req_out;
		end
	end
	sod_decoder DUT (.ref_clk_in, .arst_n_in, .sclk_in, .cs_n_in, .din_in, .crc_en_in,
		.trim_enable_bit_in, .standby_out, .converting_out, .continuous_read_out, .locked_out,
		.filter_restart_out, .reg_defaults_out, .single_read_out, .offset_trim_out,
		.xfer_valid_out, .xfer_req_out);
	sod_host host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .din_out(din_in));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wait_ref(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask : wait_ref
	function automatic logic [3:0] st();
		return {standby_out, converting_out, continuous_read_out, locked_out};
	endfunction : st
	// one command in its own frame; gap covers decode and wake spacing
	task automatic cmd(input logic [7:0] a, input logic [7:0] b, input logic two);
		host.open_frame();
		host.send_byte(a);
		if (two) host.send_byte(b);
		host.close_frame();
		wait_ref(10);
	endtask : cmd
	task automatic step(input logic [7:0] op, input logic [15:0] exp);
		cmd(op, 8'h00, 1'b0);
		chk($sformatf("op %h", op), {st(), n_restart, n_single, n_trim}, exp);
	endtask : step
	task automatic t_system();
		host.open_frame();
		fork
			host.send_byte(8'h08);
			begin
				repeat (7) @(negedge sclk_in);
				#60;
				chk("seventh edge", {15'h0, converting_out}, 16'h1);
			end
		join
		host.close_frame();
		wait_ref(10);
		chk("start", {st(), n_restart, n_single, n_trim}, 16'h6100);
		step(8'h08, 16'h6100);
		step(8'h0a, 16'h2100);
		step(8'h0a, 16'h2100);
		step(8'h04, 16'ha100);
		step(8'h02, 16'h2100);
		step(8'h11, 16'h0100);
		step(8'h12, 16'h0110);
		step(8'h1a, 16'h0110);
		trim_enable_bit_in <= 1'b1;
		step(8'h1a, 16'h0111);
		step(8'hff, 16'h0111);
		step(8'h01, 16'h0111);
		step(8'h10, 16'h2111);
	endtask : t_system
	task automatic t_xfer();
		cmd(8'h25, 8'h03, 1'b1);
		chk("register_read_cmd in cont", {14'h0, n_xfer}, 16'h0);
		cmd(8'h11, 8'h00, 1'b0);
		cmd(8'h3f, 8'h1f, 1'b1);
		chk("register_read_cmd", {n_xfer, last_req}, {2'd1, sod_pkg::SOD_CMD_REGISTER_READ_CMD, 5'h1f, 5'h1f});
		cmd(8'h40, 8'h00, 1'b1);
		chk("register_write_cmd", {n_xfer, last_req}, {2'd2, sod_pkg::SOD_CMD_REGISTER_WRITE_CMD, 5'h00, 5'h00});
		cmd(8'h60, 8'h05, 1'b1);
		chk("fifo", {n_xfer, last_req}, {2'd3, sod_pkg::SOD_CMD_FIFO, 5'h00, 5'h05});
		cmd(8'h20, 8'h25, 1'b1);
		chk("bad count", {14'h0, n_xfer}, 16'h3);
	endtask : t_xfer
	task automatic t_lock();
		host.open_frame();
		host.send_byte(8'h15);
		chk("locked", {12'h0, st()}, 16'h1);
		host.send_byte(8'h08);
		chk("start refused", {12'h0, st()}, 16'h1);
		host.send_byte(8'h12);
		chk("read while locked", {12'h0, n_single}, 16'h2);
		host.send_byte(8'h16);
		chk("unlocked", {12'h0, st()}, 16'h0);
		host.send_byte(8'h15);
		host.close_frame();
		wait_ref(10);
		chk("cs clears lock", {12'h0, st()}, 16'h0);
	endtask : t_lock
	task automatic t_reset();
		cmd(8'h08, 8'h00, 1'b0);
		cmd(8'h06, 8'h00, 1'b0);
		chk("reset cmd", {8'h0, st(), n_defaults}, 16'h0021);
		wait_ref(40);
	endtask : t_reset
	task automatic t_crc();
		@(posedge ref_clk_in);
		crc_en_in <= 1'b1;
		// throwaway frame lets the serial side pick up the enable
		cmd(8'hff, 8'hff, 1'b1);
		cmd(8'h08, 8'h38, 1'b1);
		chk("crc start", {12'h0, st()}, 16'h6);
		cmd(8'h0a, 8'h00, 1'b1);
		chk("crc wrong", {12'h0, st()}, 16'h6);
		cmd(8'h0a, 8'h36, 1'b1);
		chk("crc stop", {12'h0, st()}, 16'h2);
		cmd(8'h04, 8'h1c, 1'b1);
		chk("crc standby", {12'h0, st()}, 16'ha);
		cmd(8'h02, 8'h0e, 1'b1);
		chk("crc wake", {12'h0, st()}, 16'h2);
	endtask : t_crc
	initial begin
		arst_n_in = 1'b0;
		crc_en_in = 1'b0;
		trim_enable_bit_in = 1'b0;
		repeat (10) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		wait_ref(3);
		chk("power up", {12'h0, st()}, 16'h2);
		t_system();
		t_xfer();
		t_lock();
		t_reset();
		t_crc();
		wrap_up();
	end
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
endmodule : sod_decoder_tb_top
